// ### verilog/integrating_adc_serial_control.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module integrating_adc_serial_control
  import adc_ctrl_pkg::*;
#(
  parameter int DEINT_MAX = DEINT_MAX_PERIODS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  // Serial port pins
  input wire logic selectN,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic doutEnN,
  // Oscillator and analog front end
  input wire logic osc,
  input wire logic compZero,
  input wire logic compNeg,
  output logic integEn,
  output logic deintEn,
  // Device pins
  output logic user_out_0,
  output logic user_out_1,
  output logic user_out_2,
  output logic user_out_3,
  output logic eoc,
  output logic irq,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  pins_type pinAsync; // Raw pins gathered
  pins_type pinLevel; // Settled levels
  pins_type pinRise; // One-cycle rising edges
  pins_type pinFall; // One-cycle falling edges

  assign pinAsync = '{selectN: selectN, sclk: sclk, din: din, osc: osc,
                      compZero: compZero, compNeg: compNeg};

  // All pins share one synchroniser so din stays aligned with sclk
  edge_sync #(
    .WIDTH(PIN_COUNT)
  ) pinSync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async(pinAsync),
    .level(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );

  // ----------------------------------------------------------------
  // Serial framing decode
  // ----------------------------------------------------------------
  wire selected; // Host holds select low
  wire shiftInNow; // Capture one input bit
  wire shiftOutNow; // Launch the next output bit
  wire commitNow; // End of frame
  wire loadNow; // Start of frame

  // Clock activity is ignored while deselected
  assign selected = ~pinLevel.selectN;
  assign shiftInNow = selected & pinRise.sclk;
  assign shiftOutNow = selected & pinFall.sclk;
  assign commitNow = pinRise.selectN;
  assign loadNow = pinFall.selectN;

  // ----------------------------------------------------------------
  // Input shift register and command register
  // ----------------------------------------------------------------
  logic [CMD_BITS-1:0] inShift; // Bits collected this frame
  cmd_type cmd; // Last committed command
  wire [CMD_BITS-1:0] next_inShift;

  // New bits enter at the bottom, so the first (D7) ends at the top
  assign next_inShift = {inShift[CMD_BITS-2:0], pinLevel.din};

  // Sample on each selected rising serial clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      inShift <= CMD_RESET;
    end else if (shiftInNow) begin
      inShift <= next_inShift;
    end
  end

  // A short frame commits whatever bits arrived; host sends whole bytes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd <= CMD_RESET;
    end else if (commitNow) begin
      cmd <= inShift;
    end
  end

  // ----------------------------------------------------------------
  // User outputs
  // ----------------------------------------------------------------
  // Levels follow the command register only after a commit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {user_out_3, user_out_2, user_out_1, user_out_0} <= 4'h0;
    end else begin
      {user_out_3, user_out_2, user_out_1, user_out_0} <= cmd.userOut;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  conv_state_type state; // Sequencer state
  conv_state_type next_state;
  logic [9:0] integCount; // Oscillator periods integrated
  logic [RESULT_BITS-1:0] deintCount; // Oscillator periods deintegrated
  logic inputNeg; // Polarity caught at end of integration
  logic [23:0] result; // Twos-complement result
  logic startPending; // Start committed while busy waits here
  wire [9:0] integTarget; // Period chosen by mode bit
  wire startReq; // Start bit seen at commit
  wire beginConv; // Sequencer leaves idle
  wire integDone; // Fixed period elapsed
  wire deintDone; // Integrator back at zero, or runaway
  wire [23:0] next_result;

  // The 50 Hz setting gives the longer count and is the reset mode
  assign integTarget = cmd.mode60 ? INTEG_PERIODS_60HZ : INTEG_PERIODS_50HZ;
  assign startReq = commitNow & inShift[4];
  assign beginConv = (state == ST_IDLE) & (startReq | startPending);
  assign integDone = (state == ST_INTEG) & pinRise.osc &
                     (integCount == integTarget - 10'd1);
  assign deintDone = (state == ST_DEINT) &
                     (pinLevel.compZero |
                      (deintCount == RESULT_BITS'(DEINT_MAX)));

  // Magnitude counts up; negative inputs are stored negated
  assign next_result = inputNeg ? -{6'h00, deintCount} : {6'h00, deintCount};

  // State transitions
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (beginConv) next_state = ST_INTEG;
      ST_INTEG: if (integDone) next_state = ST_DEINT;
      ST_DEINT: if (deintDone) next_state = ST_IDLE;
      default: next_state = ST_IDLE; // Illegal one-hot code recovers to idle
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // A start that lands mid-conversion runs next rather than being lost
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      startPending <= 1'b0;
    end else if (startReq & (state != ST_IDLE)) begin
      startPending <= 1'b1;
    end else if (beginConv) begin
      startPending <= 1'b0;
    end
  end

  // Integration period counter, advanced by oscillator edges
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      integCount <= 10'h000;
    end else if (beginConv) begin
      integCount <= 10'h000;
    end else if ((state == ST_INTEG) & pinRise.osc) begin
      integCount <= integCount + 10'd1;
    end
  end

  // Deintegration counter; its final value is the magnitude
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      deintCount <= '0;
    end else if (integDone) begin
      deintCount <= '0;
    end else if ((state == ST_DEINT) & pinRise.osc & ~deintDone) begin
      deintCount <= deintCount + RESULT_BITS'(1);
    end
  end

  // Polarity of the integrated input decides the sign
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      inputNeg <= 1'b0;
    end else if (integDone) begin
      inputNeg <= pinLevel.compNeg;
    end
  end

  // Result holds until the next conversion ends
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result <= 24'h000000;
    end else if (deintDone) begin
      result <= next_result;
    end
  end

  // Analog switch controls registered from the next-state decode
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      integEn <= 1'b0;
      deintEn <= 1'b0;
    end else begin
      integEn <= (next_state == ST_INTEG);
      deintEn <= (next_state == ST_DEINT);
    end
  end

  // ----------------------------------------------------------------
  // End of conversion
  // ----------------------------------------------------------------
  wire resultRead; // Host loads the last result byte
  wire eocClear;

  // Reading the low byte completes a result read
  assign resultRead = loadNow & (cmd.readSel == SEL_RESULT_LO);
  assign eocClear = resultRead | beginConv;

  // Completion wins over a clear landing in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      eoc <= 1'b0;
    end else if (deintDone) begin
      eoc <= 1'b1;
    end else if (eocClear) begin
      eoc <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output register selection and output shift register
  // ----------------------------------------------------------------
  wire [7:0] statusByte; // Readable device state
  wire [7:0] outSelected; // Register chosen by last command
  logic [CMD_BITS-1:0] outShift; // Bits still to send

  assign statusByte = {eoc, state, cmd.mode60, startPending, 2'h0};

  // The committed command, not the frame in flight, picks the source
  assign outSelected = (cmd.readSel == SEL_RESULT_HI) ? result[23:16] :
                       (cmd.readSel == SEL_RESULT_MID) ? result[15:8] :
                       (cmd.readSel == SEL_RESULT_LO) ? result[7:0] :
                       statusByte;

  // Load at frame start, move one place per falling clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      outShift <= 8'h00;
    end else if (loadNow) begin
      outShift <= outSelected;
    end else if (shiftOutNow) begin
      outShift <= {outShift[CMD_BITS-2:0], 1'b0};
    end
  end

  // Data pin: D7 appears at load, later bits after each falling edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dout <= 1'b0;
      doutEnN <= 1'b1;
    end else begin
      dout <= loadNow ? outSelected[7] : (shiftOutNow ? outShift[6] : dout);
      doutEnN <= pinLevel.selectN & ~loadNow;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: decode
  // ----------------------------------------------------------------
  irq_type irqStatus; // Sticky events
  irq_type irqMask; // 1 lets the event reach irq
  irq_type irqEvent; // This cycle's events
  wire apbSetup; // Setup phase seen
  wire apbDone; // Access completes this edge
  wire hitStatus, hitMask, hitState, hitResult, hitAny; // Address decode
  wire [31:0] readMux;

  assign apbSetup = psel & ~penable;
  assign apbDone = psel & penable & pready;
  assign hitStatus = (paddr == ADDR_IRQ_STATUS);
  assign hitMask = (paddr == ADDR_IRQ_MASK);
  assign hitState = (paddr == ADDR_STATE);
  assign hitResult = (paddr == ADDR_RESULT);
  assign hitAny = hitStatus | hitMask | hitState | hitResult;

  // Unmapped addresses read as zero
  assign readMux = hitStatus ? {30'h00000000, irqStatus} :
                   hitMask ? {30'h00000000, irqMask} :
                   hitState ? {16'h0000, statusByte, cmd} :
                   hitResult ? {8'h00, result} :
                   32'h00000000;

  // ----------------------------------------------------------------
  // APB slave: answer, one wait-free access phase
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apbSetup;
      pslverr <= apbSetup & ~hitAny;
      prdata <= apbSetup ? readMux : 32'h00000000;
    end
  end

  // Mask register, writable; status is read-only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqMask <= IRQ_MASK_RESET;
    end else if (apbDone & pwrite & hitMask) begin
      irqMask <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irqEvent = '{cmdCommit: commitNow, convDone: deintDone};

  // Reading status clears it, but an event in that cycle survives
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqStatus <= '0;
    end else if (apbDone & ~pwrite & hitStatus) begin
      irqStatus <= irqEvent;
    end else begin
      irqStatus <= irqStatus | irqEvent;
    end
  end

  // Level output, one cycle behind the status bits
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

endmodule

// ### verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Conversion timing, in oscillator periods
  // ----------------------------------------------------------------
  localparam logic [9:0] INTEG_PERIODS_50HZ = 10'd655; // Longer, preferred default
  localparam logic [9:0] INTEG_PERIODS_60HZ = 10'd545;
  localparam int DEINT_MAX_PERIODS = 262143; // Runaway guard on deintegration
  localparam int RESULT_BITS = 18;

  // ----------------------------------------------------------------
  // Serial command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // Command byte fields, D7 first on the wire
  typedef struct packed {
    logic [1:0] readSel; // D7..D6: output register for the next frame
    logic mode60; // D5: 1 selects 60 Hz integration period
    logic start; // D4: begin a conversion on commit
    logic [3:0] userOut; // D3..D0: user output levels
  } cmd_type;

  // Output register select codes
  localparam logic [1:0] SEL_RESULT_HI = 2'h0;
  localparam logic [1:0] SEL_RESULT_MID = 2'h1;
  localparam logic [1:0] SEL_RESULT_LO = 2'h2;
  localparam logic [1:0] SEL_STATUS = 2'h3;

  // ----------------------------------------------------------------
  // APB register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0C;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Interrupt event layout, shared by status and mask
  typedef struct packed {
    logic cmdCommit; // Bit 1: a serial command was committed
    logic convDone; // Bit 0: a conversion finished
  } irq_type;

  // Conversion sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_INTEG = 3'b010,
    ST_DEINT = 3'b100
  } conv_state_type;

  // Synchronised pin inputs
  typedef struct packed {
    logic selectN;
    logic sclk;
    logic din;
    logic osc;
    logic compZero;
    logic compNeg;
  } pins_type;
  localparam int PIN_COUNT = 6;

endpackage

// ### verilog/edge_sync.sv
`timescale 1ns/100ps
module edge_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  // ----------------------------------------------------------------
  // Two-flop synchroniser plus one history stage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage1; // Metastable stage, read only by stage2
  logic [WIDTH-1:0] stage2; // Settled level
  logic [WIDTH-1:0] stage3; // Previous settled level for edges

  // Reset to all ones so a high-idle select sees no false edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
    end else begin
      stage1 <= async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Edges compare settled stages only
  assign level = stage2;
  assign rise = stage2 & ~stage3;
  assign fall = ~stage2 & stage3;

endmodule

// ### tb/integrating_adc_serial_control_sva.sv
`timescale 1ns/100ps
// --------------------
// Port checks of the serial control block
// --------------------
module adc_ctrl_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic selectN,
  input wire logic sclk,
  input wire logic dout,
  input wire logic doutEnN,
  input wire logic integEn,
  input wire logic deintEn,
  input wire logic user_out_0,
  input wire logic user_out_1,
  input wire logic user_out_2,
  input wire logic user_out_3,
  input wire logic eoc,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic [3:0] userOuts; // All four user levels
  logic [3:0] sinceRise; // Cycles since select rose, saturating
  assign userOuts = {user_out_3, user_out_2, user_out_1, user_out_0};
  // Restart on each commit, so a late or spurious output change stands out
  always_ff @(posedge core_clk) begin
    if (sys_rst || $rose(selectN)) begin
      sinceRise <= 4'h0;
    end else if (sinceRise != 4'hF) begin
      sinceRise <= sinceRise + 4'h1;
    end
  end
  a_dout_released: assert property (selectN [*8] |-> doutEnN)
    else $error("Data out driven while deselected");
  a_drive_selected: assert property ($fell(doutEnN) |-> !selectN && !$past(selectN, 2))
    else $error("Data out enabled without select");
  a_drive_soon: assert property (!selectN [*8] |-> !doutEnN)
    else $error("Data out not driven while selected");
  a_dout_stable: assert property (!selectN && sclk && $past(sclk, 5) |-> $stable(dout))
    else $error("Data out moved while serial clock high");
  a_user_hold: assert property ($changed(userOuts) |-> sinceRise <= 4'h8)
    else $error("User outputs moved without a commit");
  a_eoc_rise: assert property ($fell(deintEn) |-> ##[0:2] eoc)
    else $error("No end of conversion after deintegration");
  a_phase_excl: assert property (!(integEn && deintEn))
    else $error("Both analog phases active");
  a_phase_order: assert property ($fell(integEn) |-> ##[0:2] deintEn)
    else $error("Deintegration did not follow integration");
  a_eoc_clear: assert property ($rose(integEn) |-> ##[0:2] !eoc)
    else $error("End of conversion kept over a new start");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("Bus access not answered");
  c_frame: cover property ($rose(selectN));
  c_conv: cover property ($fell(deintEn));
  c_bus: cover property (psel && penable && pready);
endmodule
bind integrating_adc_serial_control adc_ctrl_checker adc_ctrl_checker_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .selectN(selectN), .sclk(sclk),
  .dout(dout), .doutEnN(doutEnN), .integEn(integEn), .deintEn(deintEn),
  .user_out_0(user_out_0), .user_out_1(user_out_1), .user_out_2(user_out_2),
  .user_out_3(user_out_3), .eoc(eoc), .psel(psel), .penable(penable), .pready(pready)
);

// ### tb/adc_host_model.sv
`timescale 1ns/100ps
// --------------------
// Host side of the serial port
// --------------------
module adc_host_model (
  input wire logic core_clk,
  input wire logic dout,
  input wire logic doutEnN,
  output logic selectN,
  output logic sclk,
  output logic din
);
  logic flip; // Toggles each cycle, stands for a floating line
  logic pinData; // Level the host really sees
  assign pinData = doutEnN ? flip : dout;
  initial begin
    selectN = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    flip = 1'b0;
  end
  always @(posedge core_clk) begin
    flip <= ~flip;
  end
  // One byte each way; clock only runs inside the frame
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    int i;
    selectN <= 1'b0;
    din <= tx[7];
    repeat (100) @(posedge core_clk);
    for (i = 7; i >= 0; i--) begin
      repeat (8) @(posedge core_clk);
      rx[i] = pinData;
      sclk <= 1'b1;
      repeat (8) @(posedge core_clk);
      sclk <= 1'b0;
      if (i > 0) begin
        din <= tx[i-1];
      end
    end
    repeat (80) @(posedge core_clk);
    selectN <= 1'b1;
    din <= ~tx[0]; // Stale data would hide a late sample
    repeat (200) @(posedge core_clk);
  endtask
  // Clock and data activity while deselected
  task automatic noise();
    repeat (4) begin
      sclk <= 1'b1;
      din <= ~din;
      repeat (8) @(posedge core_clk);
      sclk <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
  endtask
endmodule

// ### tb/test_integrating_adc_serial_control.sv
`timescale 1ns/100ps
module test_integrating_adc_serial_control
  import adc_ctrl_pkg::*;
();
  // --------------------
  // Pins and bench model
  // --------------------
  logic core_clk, sys_rst, selectN, sclk, din, dout, doutEnN;
  logic osc = 1'b0; // Runs only during a phase, so counts stay exact
  logic compZero = 1'b0;
  logic compNeg = 1'b0;
  logic integEn, deintEn, eoc, irq, pready, pslverr, rxKnown;
  logic user_out_0, user_out_1, user_out_2, user_out_3;
  logic psel, penable, pwrite;
  logic [7:0] paddr, lastCmd;
  logic [31:0] pwdata, prdata;
  logic [23:0] res; // Expected result word
  int stat, mask, nInteg, nDeint, target, ph, cyc, nFail, checked;
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  integrating_adc_serial_control #(.DEINT_MAX(50)) integrating_adc_serial_control_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .selectN(selectN), .sclk(sclk), .din(din),
    .dout(dout), .doutEnN(doutEnN), .osc(osc), .compZero(compZero), .compNeg(compNeg),
    .integEn(integEn), .deintEn(deintEn), .user_out_0(user_out_0),
    .user_out_1(user_out_1), .user_out_2(user_out_2), .user_out_3(user_out_3),
    .eoc(eoc), .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  adc_host_model adc_host_model_inst (
    .core_clk(core_clk), .dout(dout), .doutEnN(doutEnN),
    .selectN(selectN), .sclk(sclk), .din(din)
  );
  // Oscillator of 10 cycles; comparator trips after the chosen deint count
  always @(posedge core_clk) begin
    if (!(integEn || deintEn)) begin
      ph <= 0;
      osc <= 1'b0;
      compZero <= 1'b0;
    end else begin
      ph <= (ph == 9) ? 0 : ph + 1;
      osc <= (ph < 5);
      if (ph == 0 && !osc && integEn) begin
        nInteg <= nInteg + 1;
      end else if (ph == 0 && !osc) begin
        nDeint <= nDeint + 1;
      end
      // Comparator trips between oscillator edges, after the last counted rise
      if (ph == 2 && deintEn && nDeint == target) begin
        compZero <= 1'b1;
      end
    end
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      nFail++;
      conclude();
    end
  end
  // --------------------
  // Tasks
  // --------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Ends on pready; only the hang guard ends a wait that never sees it
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic errExp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk("read data", exp, d);
    chk("slave error", errExp, e);
  endtask
  task automatic setMask(input logic [1:0] v);
    logic [31:0] d;
    logic e;
    d = $urandom;
    apb(1'b1, ADDR_IRQ_MASK, {d[31:2], v}, d, e);
    mask = v;
  endtask
  task automatic irqChk();
    repeat (3) @(posedge core_clk);
    chk("irq", |(stat & mask), irq);
  endtask
  // Status read returns every event since the last read, then clears
  task automatic readStat();
    rdchk(ADDR_IRQ_STATUS, stat, 1'b0);
    stat = 0;
    irqChk();
  endtask
  // Output register picked by the previously committed command
  function automatic logic [7:0] outReg(input logic [1:0] s);
    case (s)
      SEL_RESULT_HI: return res[23:16];
      SEL_RESULT_MID: return res[15:8];
      SEL_RESULT_LO: return res[7:0];
      default: return {1'b0, 3'b001, lastCmd[5], 3'b000};
    endcase
  endfunction
  function automatic logic [7:0] mk(input logic [1:0] s, input logic md, input logic st);
    logic [31:0] x;
    x = $urandom;
    return {s, md, st, x[3:0]};
  endfunction
  task automatic xfer(input logic [7:0] cmd);
    logic [7:0] rx;
    logic [7:0] exp;
    exp = outReg(lastCmd[7:6]);
    adc_host_model_inst.frame(cmd, rx);
    if (rxKnown) chk("serial out", exp, rx);
    rxKnown = 1'b1;
    lastCmd = cmd;
    stat = stat | 2;
    chk("user outs", cmd[3:0], {user_out_3, user_out_2, user_out_1, user_out_0});
  endtask
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    int m;
    int k;
    logic [31:0] d;
    logic e;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {stat, nInteg, nDeint, target, ph, cyc, nFail, checked} = '0;
    rxKnown = 1'b0; // Result resets to zero, but the first reply is left unchecked
    lastCmd = CMD_RESET;
    res = 24'h0;
    void'($urandom(36));
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdchk(ADDR_IRQ_MASK, IRQ_MASK_RESET, 1'b0);
    rdchk(8'h10, 32'h0, 1'b1);
    setMask(2'h2);
    adc_host_model_inst.noise();
    rdchk(ADDR_IRQ_STATUS, 32'h0, 1'b0);
    xfer(mk(SEL_STATUS, 1'b0, 1'b0));
    irqChk();
    apb(1'b0, ADDR_STATE, 32'h0, d, e);
    chk("state", {8'h10, lastCmd}, d[15:0]);
    readStat();
    setMask(2'h1);
    for (m = 0; m < 2; m++) begin
      target = 1 + $urandom_range(39);
      compNeg <= 1'($urandom);
      nInteg = 0;
      nDeint = 0;
      xfer(mk(SEL_RESULT_HI, m[0], 1'b1));
      chk("eoc at start", 1'b0, eoc);
      k = 0;
      while (eoc !== 1'b1 && k < 20000) begin
        @(posedge core_clk);
        k++;
      end
      chk("eoc", 1'b1, eoc);
      chk("integ periods", m ? INTEG_PERIODS_60HZ : INTEG_PERIODS_50HZ, nInteg);
      chk("deint periods", target, nDeint);
      res = compNeg ? 24'h0 - 24'(target) : 24'(target);
      stat = stat | 1;
      irqChk();
      readStat();
      apb(1'b0, ADDR_RESULT, 32'h0, d, e);
      chk("result", res, d[23:0]);
    end
    xfer(mk(SEL_RESULT_MID, 1'b1, 1'b0));
    xfer(mk(SEL_RESULT_LO, 1'b1, 1'b0));
    chk("eoc kept", 1'b1, eoc);
    xfer(mk(SEL_STATUS, 1'b1, 1'b0));
    chk("eoc cleared", 1'b0, eoc);
    xfer(mk(SEL_STATUS, 1'b0, 1'b0));
    conclude();
  end
endmodule
